// ### rtl/hpf_pkg.sv
// Constants and types for the header packet framer and its CRC engine.
// Assumes one symbol per core_clk cycle on both symbol paths.
//
// What this block does
// - Multi-byte fields go least significant byte first
// - Header packet is exactly twenty symbols long
// - Start set: three SHP then one EPF
// - Send and recognise packets only after start set
// - Header: twelve info bytes plus CRC-16
// - CRC-16 polynomial is 100Bh
// - CRC-16 register preset to FFFFh
// - CRC-16 over info bytes, bit 0 first
// - Transmitter inverts final CRC-16 remainder
// - Receiver accepts header when residual is F6AAh
// - CRC-16 result bit i to field 15-i
// - Control word: seq, reserved, hub, delayed, deferred, CRC-5
// - CRC-5 polynomial 00101b, preset 11111b
// - CRC-5 covers control word bits 0 to 10
// - Inverted CRC-5 MSb at bit 11, LSb 15
// - Control word valid when residual is 01100b
// - Data packet is header then framed payload; this block handles only the header and hunts again after it
package hpf_pkg;

  localparam int          SYM_TOTAL     = 20;
  localparam int          START_SYMS    = 4;
  localparam int          HDR_BYTES     = 12;
  localparam int          BODY_BYTES    = 16;
  localparam logic [4:0]  IDX_HDR0      = 5'h04;
  localparam logic [4:0]  IDX_CRC0      = 5'h10;
  localparam logic [4:0]  IDX_LCW0      = 5'h12;
  localparam logic [4:0]  IDX_EPF       = 5'h03;
  localparam logic [4:0]  IDX_LAST      = 5'h13;
  localparam logic [3:0]  RX_CRC0       = 4'hc;
  localparam logic [3:0]  RX_LCW0       = 4'he;
  localparam logic [3:0]  RX_LAST       = 4'hf;
  localparam logic [15:0] CRC16_POLY    = 16'h100b;
  localparam logic [15:0] CRC16_INIT    = 16'hffff;
  localparam logic [15:0] CRC16_RESID   = 16'hf6aa;
  localparam logic [4:0]  CRC5_POLY     = 5'h05;
  localparam logic [4:0]  CRC5_INIT     = 5'h1f;
  localparam logic [4:0]  CRC5_RESID    = 5'h0c;
  localparam int          LCW_INFO_BITS = 11;
  localparam int          LCW_CRC_LSB   = 11;
  localparam logic [2:0]  START_MIN_HIT = 3'h3;

  typedef struct packed {
    logic       k;
    logic [7:0] d;
  } sym_type;

  // Bit 0 is seq[0]; bit 10 is the deferred flag
  typedef struct packed {
    logic       deferred;
    logic       delayed;
    logic [2:0] hub_depth;
    logic [2:0] rsvd;
    logic [2:0] seq;
  } lcw_info_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01
  } tx_state_type;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_BODY = 2'b01
  } rx_state_type;

endpackage : hpf_pkg

// ### rtl/crc_step.sv
// Combinational serial CRC advance over N data bits, bit 0 first.
// Assumes the caller holds the running remainder in its own register.
`timescale 1ns/10ps
module crc_step #(
  parameter int         W    = 16,
  parameter int         N    = 8,
  parameter logic [W-1:0] POLY = '0
) (
  input  wire logic [W-1:0] crc_in,   // Running remainder
  input  wire logic [N-1:0] data_in,  // Bits, bit 0 processed first
  output logic      [W-1:0] crc_out   // Remainder after N bits
);

  always_comb begin
    logic [W-1:0] c;
    logic         fb;
    c  = crc_in;
    fb = 1'b0;
    for (int i = 0; i < N; i++) begin
      fb = c[W-1] ^ data_in[i];
      c  = {c[W-2:0], 1'b0} ^ (fb ? POLY : '0);
    end
    crc_out = c;
  end

endmodule : crc_step

// ### rtl/header_packet_framer_crc.sv
// Header packet framer: builds and checks twenty-symbol header packets.
// Assumes both symbol paths are synchronous to core_clk, one symbol a cycle.
`timescale 1ns/10ps
module header_packet_framer_crc
  import hpf_pkg::*;
#(
  parameter logic [7:0] SHP_CODE = 8'h5c,  // Start-of-header K code
  parameter logic [7:0] EPF_CODE = 8'hf7   // End-of-framing K code
) (
  input  wire logic         core_clk,       // Symbol clock
  input  wire logic         reset,          // Synchronous, active high
  input  wire logic         clk_en,         // Freezes all state when low
  input  wire logic         tx_req_valid,   // Header offered for sending
  output logic              tx_req_ready,   // Header taken this cycle
  input  wire logic [95:0]  tx_hdr,         // Byte n in bits 8n+7:8n
  input  wire lcw_info_type tx_lcw,         // Control word information
  output sym_type           tx_sym,         // Symbol toward the link
  output logic              tx_sym_valid,   // tx_sym holds a symbol
  input  wire logic         tx_sym_ready,   // Link takes tx_sym
  output logic              tx_busy,        // Packet in progress
  input  wire sym_type      rx_sym,         // Symbol from the link
  input  wire logic         rx_sym_valid,   // rx_sym holds a symbol
  output logic [95:0]       rx_hdr,         // Received header information
  output lcw_info_type      rx_lcw,         // Received control word
  output logic              rx_hdr_valid,   // Pulse: packet passed checks
  output logic              rx_crc16_err,   // Pulse: header CRC failed
  output logic              rx_crc5_err,    // Pulse: control word CRC bad
  output logic              rx_frame_err    // Pulse: K symbol in body
);

  // Transmit side
  tx_state_type tx_state_q;
  logic [4:0]   tx_idx_q;
  logic [95:0]  tx_hdr_q;
  lcw_info_type tx_lcw_q;
  logic [15:0]  tx_crc_q;
  logic [15:0]  tx_crc_next;
  logic [4:0]   tx_crc5;
  logic [15:0]  tx_crc_field;
  logic [15:0]  tx_lcw_word;
  logic [3:0]   tx_hdr_sel;
  logic [7:0]   tx_byte;
  sym_type      tx_sym_d;
  sym_type      tx_sym_q;
  logic         tx_sym_valid_q;
  logic         tx_adv;
  logic         tx_take;

  assign tx_busy      = (tx_state_q == TX_SEND);
  assign tx_req_ready = clk_en && (tx_state_q == TX_IDLE);
  assign tx_take      = tx_req_ready && tx_req_valid;
  assign tx_adv       = clk_en && tx_busy
                        && (!tx_sym_valid_q || tx_sym_ready);
  assign tx_sym       = tx_sym_q;
  assign tx_sym_valid = tx_sym_valid_q;
  assign tx_hdr_sel   = 4'(tx_idx_q - IDX_HDR0);
  // Slots outside the header bytes read zero, never past the vector
  assign tx_byte      = (tx_hdr_sel < 4'(HDR_BYTES))
                        ? tx_hdr_q[8*tx_hdr_sel +: 8] : 8'h00;

  crc_step #(
    .W    (16),
    .N    (8),
    .POLY (CRC16_POLY)
  ) u_tx_crc16 (
    .crc_in  (tx_crc_q),
    .data_in (tx_byte),
    .crc_out (tx_crc_next)
  );

  crc_step #(
    .W    (5),
    .N    (LCW_INFO_BITS),
    .POLY (CRC5_POLY)
  ) u_tx_crc5 (
    .crc_in  (CRC5_INIT),
    .data_in (tx_lcw_q),
    .crc_out (tx_crc5)
  );

  // Inverted and bit-reversed check fields
  always_comb begin
    tx_crc_field = '0;
    tx_lcw_word  = {5'h00, tx_lcw_q};
    for (int i = 0; i < 16; i++) begin
      tx_crc_field[15-i] = ~tx_crc_q[i];
    end
    for (int j = 0; j < 5; j++) begin
      tx_lcw_word[LCW_CRC_LSB+j] = ~tx_crc5[4-j];
    end
  end

  // Symbol for the current slot of the packet
  always_comb begin
    tx_sym_d = '0;
    if (tx_idx_q < IDX_HDR0) begin
      tx_sym_d.k = 1'b1;
      tx_sym_d.d = (tx_idx_q == IDX_EPF) ? EPF_CODE : SHP_CODE;
    end else if (tx_idx_q < IDX_CRC0) begin
      tx_sym_d.d = tx_byte;
    end else if (tx_idx_q < IDX_LCW0) begin
      tx_sym_d.d = (tx_idx_q == IDX_CRC0) ? tx_crc_field[7:0]
                                          : tx_crc_field[15:8];
    end else begin
      tx_sym_d.d = (tx_idx_q == IDX_LCW0) ? tx_lcw_word[7:0]
                                          : tx_lcw_word[15:8];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_state_q <= TX_IDLE;
      tx_idx_q   <= '0;
    end else if (tx_take) begin
      tx_state_q <= TX_SEND;
      tx_idx_q   <= '0;
    end else if (tx_adv) begin
      if (tx_idx_q == IDX_LAST) begin
        tx_state_q <= TX_IDLE;
        tx_idx_q   <= '0;
      end else begin
        tx_idx_q <= tx_idx_q + 5'h01;
      end
    end
  end

  // Capture of the offered header; reserved bits go out as zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_hdr_q <= '0;
      tx_lcw_q <= '0;
    end else if (tx_take) begin
      tx_hdr_q      <= tx_hdr;
      tx_lcw_q      <= tx_lcw;
      tx_lcw_q.rsvd <= 3'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_crc_q <= CRC16_INIT;
    end else if (tx_take) begin
      tx_crc_q <= CRC16_INIT;
    end else if (tx_adv && tx_idx_q >= IDX_HDR0
                 && tx_idx_q < IDX_CRC0) begin
      tx_crc_q <= tx_crc_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_sym_q       <= '0;
      tx_sym_valid_q <= 1'b0;
    end else if (tx_adv) begin
      tx_sym_q       <= tx_sym_d;
      tx_sym_valid_q <= 1'b1;
    end else if (clk_en && tx_sym_ready) begin
      tx_sym_valid_q <= 1'b0;
    end
  end

  // Receive side
  rx_state_type rx_state_q;
  sym_type      rx_win_q [3];
  logic [2:0]   rx_hits;
  logic [3:0]   rx_cnt_q;
  logic [15:0]  rx_crc_q;
  logic [15:0]  rx_crc_next;
  logic [7:0]   rx_lcw_lo_q;
  logic [4:0]   rx_crc5_res;
  logic         rx_take;
  logic         rx_crc16_ok;
  logic         rx_crc5_ok;

  assign rx_take = clk_en && rx_sym_valid;

  // Start set match, tolerating one bad symbol
  always_comb begin
    rx_hits = '0;
    for (int i = 0; i < 3; i++) begin
      rx_hits = rx_hits + 3'((rx_win_q[i].k
                              && rx_win_q[i].d == SHP_CODE) ? 1 : 0);
    end
    rx_hits = rx_hits + 3'((rx_sym.k && rx_sym.d == EPF_CODE) ? 1 : 0);
  end

  crc_step #(
    .W    (16),
    .N    (8),
    .POLY (CRC16_POLY)
  ) u_rx_crc16 (
    .crc_in  (rx_crc_q),
    .data_in (rx_sym.d),
    .crc_out (rx_crc_next)
  );

  crc_step #(
    .W    (5),
    .N    (16),
    .POLY (CRC5_POLY)
  ) u_rx_crc5 (
    .crc_in  (CRC5_INIT),
    .data_in ({rx_sym.d, rx_lcw_lo_q}),
    .crc_out (rx_crc5_res)
  );

  assign rx_crc16_ok = (rx_crc_q == CRC16_RESID);
  assign rx_crc5_ok  = (rx_crc5_res == CRC5_RESID);

  // Window of the last three symbols for start-set search
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < 3; i++) begin
        rx_win_q[i] <= '0;
      end
    end else if (rx_take) begin
      rx_win_q[0] <= rx_win_q[1];
      rx_win_q[1] <= rx_win_q[2];
      rx_win_q[2] <= rx_sym;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_state_q <= RX_HUNT;
      rx_cnt_q   <= '0;
    end else if (rx_take) begin
      case (rx_state_q)
        RX_HUNT: begin
          if (rx_hits >= START_MIN_HIT) begin
            rx_state_q <= RX_BODY;
            rx_cnt_q   <= '0;
          end
        end
        RX_BODY: begin
          if (rx_sym.k || rx_cnt_q == RX_LAST) begin
            // Hunt again, so a trailing payload is not read as body
            rx_state_q <= RX_HUNT;
            rx_cnt_q   <= '0;
          end else begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
          end
        end
        default: begin
          rx_state_q <= RX_HUNT;
          rx_cnt_q   <= '0;
        end
      endcase
    end
  end

  // CRC-16 runs over info bytes and the received check field
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_crc_q <= CRC16_INIT;
    end else if (rx_take) begin
      if (rx_state_q == RX_HUNT) begin
        rx_crc_q <= CRC16_INIT;
      end else if (rx_cnt_q < RX_LCW0) begin
        rx_crc_q <= rx_crc_next;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_hdr      <= '0;
      rx_lcw_lo_q <= '0;
      rx_lcw      <= '0;
    end else if (rx_take && rx_state_q == RX_BODY && !rx_sym.k) begin
      if (rx_cnt_q < RX_CRC0) begin
        rx_hdr[8*rx_cnt_q +: 8] <= rx_sym.d;
      end else if (rx_cnt_q == RX_LCW0) begin
        rx_lcw_lo_q <= rx_sym.d;
      end else if (rx_cnt_q == RX_LAST) begin
        rx_lcw <= lcw_info_type'({rx_sym.d[2:0], rx_lcw_lo_q});
      end
    end
  end

  // One-cycle result pulses at the last symbol; frame error at any K symbol in the body
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_hdr_valid <= 1'b0;
      rx_crc16_err <= 1'b0;
      rx_crc5_err  <= 1'b0;
      rx_frame_err <= 1'b0;
    end else if (clk_en) begin
      rx_hdr_valid <= 1'b0;
      rx_crc16_err <= 1'b0;
      rx_crc5_err  <= 1'b0;
      rx_frame_err <= 1'b0;
      if (rx_sym_valid && rx_state_q == RX_BODY) begin
        if (rx_sym.k) begin
          rx_frame_err <= 1'b1;
        end else if (rx_cnt_q == RX_LAST) begin
          rx_hdr_valid <= rx_crc16_ok && rx_crc5_ok;
          rx_crc16_err <= !rx_crc16_ok;
          rx_crc5_err  <= !rx_crc5_ok;
        end
      end
    end
  end

endmodule : header_packet_framer_crc

// ### dv/hpf_properties.sv
// Port-level assertions for the header packet framer.
// Assumes it is bound to header_packet_framer_crc, one clock domain.
`timescale 1ns/10ps
module hpf_properties
  import hpf_pkg::*;
#(
  parameter logic [7:0] SHP_CODE = 8'h5c,
  parameter logic [7:0] EPF_CODE = 8'hf7
) (
  input wire logic    core_clk,     // Clock
  input wire logic    reset,        // Reset
  input wire logic    clk_en,       // Enable
  input wire logic    tx_req_valid, // Offer
  input wire logic    tx_req_ready, // Take
  input wire sym_type tx_sym,       // Tx symbol
  input wire logic    tx_sym_valid, // Tx valid
  input wire logic    tx_sym_ready, // Tx ready
  input wire logic    tx_busy,      // Busy
  input wire sym_type rx_sym,       // Rx symbol
  input wire logic    rx_sym_valid, // Rx valid
  input wire logic    rx_hdr_valid, // Good packet
  input wire logic    rx_crc16_err, // Header CRC bad
  input wire logic    rx_crc5_err,  // Word CRC bad
  input wire logic    rx_frame_err  // K in body
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic       acc;
  logic [4:0] pos_q;
  assign acc = tx_sym_valid && tx_sym_ready && clk_en;
  // Symbol position within the outgoing packet
  always_ff @(posedge core_clk) begin
    if (reset) pos_q <= 5'h00;
    else if (acc) pos_q <= (pos_q == 5'h13) ? 5'h00 : pos_q + 5'h01;
  end
  AST_START_SHP: assert property (acc && pos_q < 5'h03 |->
    tx_sym.k && tx_sym.d == SHP_CODE) else $error("start symbol wrong");
  AST_START_EPF: assert property (acc && pos_q == 5'h03 |->
    tx_sym.k && tx_sym.d == EPF_CODE) else $error("end of start wrong");
  AST_BODY_DATA: assert property (acc && pos_q > 5'h03 |->
    !tx_sym.k) else $error("K symbol in body");
  AST_HOLD: assert property (
    tx_sym_valid && !(tx_sym_ready && clk_en)
    |=> tx_sym_valid && $stable(tx_sym)) else $error("symbol not held");
  AST_FIRST: assert property (tx_req_valid && tx_req_ready &&
    !tx_sym_valid ##1 clk_en |=> tx_sym_valid && tx_sym.d == SHP_CODE)
    else $error("first symbol late");
  AST_BUSY_READY: assert property (tx_busy |-> !tx_req_ready)
    else $error("ready while busy");
  AST_TAKE_BUSY: assert property (tx_req_valid && tx_req_ready |=>
    tx_busy) else $error("busy missing");
  AST_BUSY_SPAN: assert property (acc && pos_q < 5'h13 |->
    tx_busy) else $error("busy dropped inside packet");
  AST_ONE_RESULT: assert property (rx_hdr_valid |->
    !(rx_crc16_err || rx_crc5_err || rx_frame_err))
    else $error("good and bad together");
  AST_FRAME_CAUSE: assert property (
    rx_frame_err && $past(clk_en) |-> $past(rx_sym_valid && rx_sym.k))
    else $error("frame error uncaused");
  AST_PULSE: assert property (rx_hdr_valid && clk_en |=>
    !rx_hdr_valid) else $error("valid pulse too long");
  AST_RESET_IDLE: assert property ($fell(reset) |-> !tx_busy &&
    !tx_sym_valid) else $error("not idle after reset");
endmodule : hpf_properties

bind header_packet_framer_crc hpf_properties #(
  .SHP_CODE(SHP_CODE), .EPF_CODE(EPF_CODE)) i_hpf_properties (
  .core_clk(core_clk), .reset(reset), .clk_en(clk_en),
  .tx_req_valid(tx_req_valid), .tx_req_ready(tx_req_ready),
  .tx_sym(tx_sym), .tx_sym_valid(tx_sym_valid),
  .tx_sym_ready(tx_sym_ready), .tx_busy(tx_busy), .rx_sym(rx_sym),
  .rx_sym_valid(rx_sym_valid), .rx_hdr_valid(rx_hdr_valid),
  .rx_crc16_err(rx_crc16_err), .rx_crc5_err(rx_crc5_err),
  .rx_frame_err(rx_frame_err));

// ### dv/link_partner.sv
// Link partner model: takes transmitted symbols and replays whole packets.
// Assumes one symbol per core_clk; damages one symbol when told to.
`timescale 1ns/10ps
module link_partner
  import hpf_pkg::*;
(
  input  wire logic       core_clk,     // Clock
  input  wire logic       reset,        // Reset
  input  wire logic       clk_en,       // Enable
  input  wire logic       slow,         // Stall every other cycle
  input  wire logic [4:0] bad_idx,      // Symbol to damage
  input  wire logic       bad_k,        // Damage sets k
  input  wire sym_type    tx_sym,       // From framer
  input  wire logic       tx_sym_valid, // From framer
  output logic            tx_sym_ready, // To framer
  output sym_type         rx_sym,       // To framer
  output logic            rx_sym_valid  // To framer
);
  sym_type    q[$];
  sym_type    s;
  logic [4:0] cnt_q;
  logic       run_q;
  always @(posedge core_clk) begin
    if (reset) begin
      tx_sym_ready <= 1'b1;
      cnt_q <= 5'h00;
      run_q <= 1'b0;
      rx_sym_valid <= 1'b0;
      rx_sym <= '0;
      q.delete();
    end else begin
      tx_sym_ready <= slow ? !tx_sym_ready : 1'b1;
      if (tx_sym_valid && tx_sym_ready && clk_en) begin
        s = tx_sym;
        if (cnt_q == bad_idx && bad_k) s.k = 1'b1;
        else if (cnt_q == bad_idx) s.d[0] = !s.d[0];
        q.push_back(s);
        cnt_q <= (cnt_q == 5'h13) ? 5'h00 : cnt_q + 5'h01;
      end
      // Replay only whole packets, without gaps
      if (clk_en && q.size() > 0 && (run_q || q.size() >= 20)) begin
        rx_sym <= q.pop_front();
        rx_sym_valid <= 1'b1;
        run_q <= (q.size() > 0);
      end else begin
        rx_sym <= ~rx_sym;
        rx_sym_valid <= 1'b0;
      end
    end
  end
endmodule : link_partner

// ### dv/header_packet_framer_crc_bench.sv
// Self-checking bench for the header packet framer, looped via a partner.
// Assumes link_partner and the bound checker are compiled alongside.
`timescale 1ns/10ps
module header_packet_framer_crc_bench;
  import hpf_pkg::*;
  logic         core_clk = 1'b0;
  logic         reset = 1'b1;
  logic         clk_en = 1'b1;
  logic         tx_req_valid = 1'b0;
  logic         slow = 1'b0;
  logic         bad_k = 1'b0;
  logic [4:0]   bad_idx = 5'h1f;
  logic [95:0]  tx_hdr = '0;
  lcw_info_type tx_lcw = '0;
  sym_type      tx_sym, rx_sym;
  logic         tx_req_ready, tx_sym_valid, tx_sym_ready, tx_busy;
  logic         rx_sym_valid, rx_hdr_valid, rx_crc16_err, rx_crc5_err;
  logic         rx_frame_err;
  logic [95:0]  rx_hdr;
  lcw_info_type rx_lcw;
  int           miscompares = 0;
  int           comparisons = 0;
  sym_type      seen[$];
  sym_type      exp_s[20];

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (tx_sym_valid && tx_sym_ready && clk_en) seen.push_back(tx_sym);

  header_packet_framer_crc #(.SHP_CODE(8'h5c), .EPF_CODE(8'hf7))
    i_header_packet_framer_crc (.core_clk(core_clk), .reset(reset),
    .clk_en(clk_en), .tx_req_valid(tx_req_valid),
    .tx_req_ready(tx_req_ready), .tx_hdr(tx_hdr), .tx_lcw(tx_lcw),
    .tx_sym(tx_sym), .tx_sym_valid(tx_sym_valid),
    .tx_sym_ready(tx_sym_ready), .tx_busy(tx_busy), .rx_sym(rx_sym),
    .rx_sym_valid(rx_sym_valid), .rx_hdr(rx_hdr), .rx_lcw(rx_lcw),
    .rx_hdr_valid(rx_hdr_valid), .rx_crc16_err(rx_crc16_err),
    .rx_crc5_err(rx_crc5_err), .rx_frame_err(rx_frame_err));
  link_partner i_link_partner (.core_clk(core_clk), .reset(reset),
    .clk_en(clk_en), .slow(slow), .bad_idx(bad_idx), .bad_k(bad_k),
    .tx_sym(tx_sym), .tx_sym_valid(tx_sym_valid),
    .tx_sym_ready(tx_sym_ready), .rx_sym(rx_sym),
    .rx_sym_valid(rx_sym_valid));

  task automatic check_v(input logic [95:0] got, input logic [95:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check_v

  // Expected symbols, worked out serially bit 0 first
  task automatic build(input logic [95:0] h, input lcw_info_type l);
    logic [15:0] c, f, w;
    logic [4:0]  c5;
    logic        fb;
    c = 16'hffff;
    c5 = 5'h1f;
    l.rsvd = 3'h0;
    for (int i = 0; i < 96; i++) begin
      fb = c[15] ^ h[i];
      c = {c[14:0], 1'b0} ^ (fb ? 16'h100b : 16'h0000);
    end
    for (int i = 0; i < 11; i++) begin
      fb = c5[4] ^ l[i];
      c5 = {c5[3:0], 1'b0} ^ (fb ? 5'h05 : 5'h00);
    end
    for (int i = 0; i < 16; i++) f[15-i] = ~c[i];
    w[10:0] = l;
    for (int j = 0; j < 5; j++) w[11+j] = ~c5[4-j];
    for (int i = 0; i < 3; i++) exp_s[i] = {1'b1, 8'h5c};
    exp_s[3] = {1'b1, 8'hf7};
    for (int n = 0; n < 12; n++) exp_s[4+n] = {1'b0, h[8*n +: 8]};
    exp_s[16] = {1'b0, f[7:0]};
    exp_s[17] = {1'b0, f[15:8]};
    exp_s[18] = {1'b0, w[7:0]};
    exp_s[19] = {1'b0, w[15:8]};
  endtask : build

  task automatic run(input logic [95:0] h, input lcw_info_type l,
                     input logic [4:0] idx, input logic k,
                     input logic [3:0] flags, input logic hold);
    int          n;
    lcw_info_type el;
    build(h, l);
    el = l;
    el.rsvd = 3'h0;
    seen.delete();
    bad_idx <= idx;
    bad_k <= k;
    tx_hdr <= h;
    tx_lcw <= l;
    tx_req_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!tx_req_ready && n < 100);
    tx_req_valid <= 1'b0;
    if (hold) begin
      clk_en <= 1'b0;
      repeat (3) @(posedge core_clk);
      clk_en <= 1'b1;
    end
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!(rx_hdr_valid || rx_crc16_err || rx_crc5_err ||
                 rx_frame_err) && n < 200);
    check_v({rx_frame_err, rx_crc5_err, rx_crc16_err, rx_hdr_valid},
            flags);
    check_v(seen.size(), 20);
    for (int i = 0; i < 20 && i < seen.size(); i++)
      check_v(seen[i], exp_s[i]);
    if (flags == 4'b0001) begin
      check_v(rx_hdr, h);
      check_v(rx_lcw, el);
    end
  endtask : run

  task automatic sc_plain;
    run(96'h0b0a_0908_0706_0504_0302_0100, 11'h7f5, 5'h1f, 1'b0,
        4'b0001, 1'b0);
  endtask : sc_plain

  task automatic sc_stall;
    slow <= 1'b1;
    run(96'hffee_ddcc_bbaa_9988_7766_5544, 11'h2c3, 5'h1f, 1'b0,
        4'b0001, 1'b1);
    slow <= 1'b0;
  endtask : sc_stall

  task automatic sc_errors;
    logic [4:0] idx[4] = '{5'h10, 5'h13, 5'h06, 5'h01};
    logic [3:0] fl[4] = '{4'b0010, 4'b0100, 4'b1000, 4'b0001};
    for (int i = 0; i < 4; i++)
      run(96'h1234_5678_9abc_def0_0f1e_2d3c, 11'h4a9, idx[i], i == 2,
          fl[i], 1'b0);
  endtask : sc_errors

  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  initial begin
    #80000;
    miscompares++;
    results();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    sc_plain();
    sc_stall();
    sc_errors();
    results();
  end
endmodule : header_packet_framer_crc_bench
